/* File: pkg/mac_status_pkg.sv */
// Constants and carrier types for the MAC status and PHY management block
package mac_status_pkg;
	localparam logic [7:0] off_rx_status = 8'h00;
	localparam logic [7:0] off_irq_status = 8'h04;
	localparam logic [7:0] off_irq_enable = 8'h08;
	localparam logic [7:0] off_irq_disable = 8'h0c;
	localparam logic [7:0] off_irq_mask = 8'h10;
	localparam logic [7:0] off_phy_maintenance = 8'h14;
	localparam logic [7:0] off_hash_filter_high = 8'h18;
	localparam logic [7:0] off_net_status_reg = 8'h1c;
	localparam logic [7:0] off_mgmt_config = 8'h20;
	localparam int rx_no_buffer = 0;
	localparam int rx_frame_stored = 1;
	localparam int rx_overrun_flag = 2;
	localparam int irq_mgmt_done = 0;
	localparam int rx_done_irq = 1;
	localparam int rx_no_buffer_irq = 2;
	localparam int tx_queue_overwrite_irq = 3;
	localparam int tx_underrun_irq = 4;
	localparam int retry_limit_irq = 5;
	localparam int tx_slot_free_irq = 6;
	localparam int tx_done_irq = 7;
	localparam int tx_all_sent_irq = 8;
	localparam int irq_link = 9;
	localparam int rx_overflow_irq = 10;
	localparam int irq_bus_error = 11;
	localparam int irq_bits = 12;
	localparam int ns_link = 0;
	localparam int ns_mdio = 1;
	localparam int ns_idle = 2;
	localparam int op_msb = 29;
	localparam int op_lsb = 28;
	localparam logic [1:0] op_read = 2'b10;
	localparam logic [1:0] op_write = 2'b01;
	localparam int mgmt_frame_bits = 32;
	localparam int mgmt_turn_bit = 16;
	localparam logic [15:0] mask_reset = 16'hffff;
	localparam logic [1:0] div_sel_reset = 2'b10;
	localparam logic [5:0] div_half_base = 6'h04;
	localparam logic [1:0] resp_okay = 2'b00;
	localparam logic [1:0] resp_decerr = 2'b11;

	typedef struct packed {
		logic fetch_done;
		logic fetch_cpu_owned;
		logic frame_start;
		logic frame_stored;
		logic overrun;
	} rx_dma_ev_t;

	typedef struct packed {
		logic reg_write;
		logic slot_free;
		logic underrun;
		logic retry_limit;
		logic frame_done;
		logic all_sent;
		logic bus_error;
	} tx_dma_ev_t;

	typedef struct packed {
		logic mdc;
		logic mdio_o;
		logic mdio_oe;
	} mdio_out_t;
endpackage : mac_status_pkg

/* File: design/mac_irq_status_phy_mgmt.sv */
// Status flags, interrupt registers, MDIO engine and hash-high of the MAC
// Notes on behaviour
// [R1] Failed descriptor fetch owned by processor sets receive no-buffer flag.
// [R2] After a failed fetch, refetch the pointer at each new frame start.
// [R3] Every failed fetch sets no-buffer again, regardless of prior clears.
// [R4] Receive status bits 0..2 clear only by writing one.
// [R5] Overrun sets status bit 2, recovers buffer, mirrors to interrupt bit 10.
// [R6] Interrupt status holds twelve event bits, all cleared when read.
// [R7] Transmit register write while slot not free raises overwrite flag.
// [R8] Transmit DMA data fetch too late raises underrun flag.
// [R9] Slot-free flag set when slot frees, cleared when queue full or read.
// [R10] All frames sent sets idle flag; each finished frame sets done flag.
// [R11] Error response seen by DMA raises bus-error flag.
// [R12] Any change of the link pin raises the link flag.
// [R13] Enable register write enables each source whose bit is one.
// [R14] Disable register write disables each source whose bit is one.
// [R15] Mask register reads masked sources; resets to all sixteen set.
// [R16] Writing maintenance loads shifter and starts frame; read gives shifter.
// [R17] Each shift drives MDIO from MSB and takes sampled pin into LSB.
// [R18] Frame end raises management-done flag and sets status idle bit.
// [R19] Operation bits 29:28: 10 read, 01 write, others invalid.
// [R20] Software writes code bits 10, bit 30 one, bit 31 zero.
// [R21] Low sixteen bits carry write data or read result; address fields above.
// [R22] Hash-high register holds filter bits 63:32, read/write, resets zero.
// [R23] MDC is clock over 8, 16, 32 or 64; reset selects 32.
// [R24] With hashing on, CRC index picking a set hash bit accepts frame.
// [R25] Network status bit 2 reads one while no management frame shifts.
// [R26] Frame shifts 32 bits MSB first; PHY drives last sixteen on read.
// [R27] Enable ones clear mask bits, disable ones set them; zeros ignored.
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
module mac_irq_status_phy_mgmt (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire mac_status_pkg::rx_dma_ev_t rx_ev,
	input wire mac_status_pkg::tx_dma_ev_t tx_ev,
	output logic rx_refetch,
	output logic rx_buffer_recover,
	input wire logic link_pin,
	input wire logic mdio_i,
	output mac_status_pkg::mdio_out_t mdio_out,
	input wire logic hash_enable,
	input wire logic [5:0] crc_index,
	input wire logic [31:0] hash_filter_low,
	output logic hash_hit,
	output logic irq
);
	import mac_status_pkg::*;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic aw_have;
		logic [7:0] awaddr;
		logic w_have;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [2:0] rx_status;
		logic [11:0] isr;
		logic [15:0] mask;
		logic [31:0] sr;
		logic busy;
		// Read frame: the PHY owns the wire for the data half
		logic rd_op;
		logic [4:0] bits;
		logic [5:0] cnt;
		logic sample;
		mdio_out_t mdio;
		logic [1:0] div_sel;
		logic [31:0] hash_high;
		logic link_prev;
		logic slot_prev;
		logic fetch_failed;
		logic refetch;
		logic recover;
		logic irq;
		logic hash_hit;
	} state_t;

	state_t s;
	state_t next_s;

	// True when the byte address names a register of this block
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == off_rx_status) || (a == off_irq_status) ||
			(a == off_irq_enable) || (a == off_irq_disable) ||
			(a == off_irq_mask) || (a == off_phy_maintenance) ||
			(a == off_hash_filter_high) || (a == off_net_status_reg) ||
			(a == off_mgmt_config);
	endfunction : mapped

	// Bytes with a strobe take the new value, others keep the old one
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// A fetch that finds the descriptor still owned by software
	function automatic logic fetch_refused(input rx_dma_ev_t ev);
		fetch_refused = ev.fetch_done && ev.fetch_cpu_owned;
	endfunction : fetch_refused

	logic do_write;
	logic do_read;
	logic [31:0] wval;
	logic [31:0] ones;
	logic [11:0] irq_set;
	logic [5:0] half;
	logic [63:0] hash_all;

	always_comb begin
		next_s = s;
		do_write = s.aw_have && s.w_have && !s.bvalid;
		do_read = s_axi_arvalid && s.arready;
		wval = s.wdata;
		ones = merge(32'h0000_0000, s.wdata, s.wstrb);
		irq_set = 12'h000;
		half = div_half_base << s.div_sel;
		hash_all = {s.hash_high, hash_filter_low};
		next_s.refetch = 1'b0;
		next_s.recover = 1'b0;

		// Write channel: address and data latch independently
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_have = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_have = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end

		// Receive DMA fetch tracking
		if (fetch_refused(rx_ev)) begin
			next_s.fetch_failed = 1'b1; // [R2]
		end else if (rx_ev.fetch_done) begin
			next_s.fetch_failed = 1'b0; // [R2]
		end
		if (s.fetch_failed && rx_ev.frame_start) begin
			next_s.refetch = 1'b1; // [R2]
		end
		if (rx_ev.overrun) begin
			next_s.recover = 1'b1; // [R5]
		end

		// Management engine timing
		if (s.busy) begin
			next_s.cnt = s.cnt + 6'h01;
			if (s.cnt == half - 6'h01) begin // [R23]
				next_s.cnt = 6'h00;
				if (!s.mdio.mdc) begin
					next_s.mdio.mdc = 1'b1;
					next_s.sample = mdio_i; // [R17]
				end else begin
					next_s.mdio.mdc = 1'b0;
					next_s.sr = {s.sr[30:0], s.sample}; // [R17] [R26]
					next_s.bits = s.bits + 5'h01;
					if (s.bits == 5'(mgmt_frame_bits - 1)) begin
						next_s.busy = 1'b0; // [R26]
						irq_set[irq_mgmt_done] = 1'b1; // [R18]
					end
				end
			end
		end

		// Event sources into interrupt status
		irq_set[rx_done_irq] = rx_ev.frame_stored;
		irq_set[rx_no_buffer_irq] = fetch_refused(rx_ev); // [R1]
		irq_set[tx_queue_overwrite_irq] = tx_ev.reg_write &&
			!tx_ev.slot_free; // [R7]
		irq_set[tx_underrun_irq] = tx_ev.underrun; // [R8]
		irq_set[retry_limit_irq] = tx_ev.retry_limit;
		irq_set[tx_slot_free_irq] = tx_ev.slot_free && !s.slot_prev; // [R9]
		irq_set[tx_done_irq] = tx_ev.frame_done; // [R10]
		irq_set[tx_all_sent_irq] = tx_ev.all_sent; // [R10]
		irq_set[irq_link] = link_pin != s.link_prev; // [R12]
		irq_set[rx_overflow_irq] = rx_ev.overrun; // [R5]
		irq_set[irq_bus_error] = tx_ev.bus_error; // [R11]
		// Edge detectors reset low: a pin high at reset gives one edge
		next_s.link_prev = link_pin;
		next_s.slot_prev = tx_ev.slot_free;

		// Register writes
		if (do_write) begin
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = mapped(s.awaddr) ? resp_okay : resp_decerr;
			unique case (s.awaddr)
				off_rx_status: begin
					next_s.rx_status = s.rx_status & ~ones[2:0]; // [R4]
				end
				off_irq_enable: begin
					next_s.mask = s.mask & ~ones[15:0]; // [R13] [R27]
				end
				off_irq_disable: begin
					next_s.mask = s.mask | ones[15:0]; // [R14] [R27]
				end
				off_phy_maintenance: begin
					// Restarts any frame under way; the old one is lost
					wval = merge(s.sr, s.wdata, s.wstrb);
					next_s.sr = wval; // [R16] [R21]
					next_s.busy = 1'b1; // [R16]
					// Direction latched now; the op field shifts away mid-frame
					next_s.rd_op = wval[op_msb:op_lsb] == op_read; // [R19]
					next_s.bits = 5'h00;
					next_s.cnt = 6'h00;
					next_s.mdio.mdc = 1'b0;
				end
				off_hash_filter_high: begin
					next_s.hash_high = merge(s.hash_high, s.wdata,
						s.wstrb); // [R22]
				end
				off_mgmt_config: begin
					if (s.wstrb[0]) begin
						next_s.div_sel = s.wdata[1:0]; // [R23]
					end
				end
				default: begin
				end
			endcase
		end

		// Receive status: hardware set wins over software clear
		next_s.rx_status[rx_no_buffer] = next_s.rx_status[rx_no_buffer] |
			fetch_refused(rx_ev); // [R1] [R3]
		next_s.rx_status[rx_frame_stored] =
			next_s.rx_status[rx_frame_stored] | rx_ev.frame_stored; // [R4]
		next_s.rx_status[rx_overrun_flag] =
			next_s.rx_status[rx_overrun_flag] | rx_ev.overrun; // [R5]

		// Reads; interrupt status clears on the read that returns it
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (do_read) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = mapped(s_axi_araddr) ? resp_okay : resp_decerr;
			next_s.rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				off_rx_status: begin
					next_s.rdata[2:0] = s.rx_status; // [R4]
				end
				off_irq_status: begin
					next_s.rdata[11:0] = s.isr;
					next_s.isr = 12'h000; // [R6]
				end
				off_irq_mask: begin
					next_s.rdata[15:0] = s.mask; // [R15]
				end
				off_phy_maintenance: begin
					next_s.rdata = s.sr; // [R16]
				end
				off_hash_filter_high: begin
					next_s.rdata = s.hash_high; // [R22]
				end
				off_net_status_reg: begin
					next_s.rdata[ns_link] = link_pin;
					next_s.rdata[ns_mdio] = mdio_i;
					next_s.rdata[ns_idle] = !s.busy; // [R18] [R25]
				end
				off_mgmt_config: begin
					next_s.rdata[1:0] = s.div_sel;
				end
				default: begin
				end
			endcase
		end
		next_s.isr = next_s.isr | irq_set; // [R6]
		if (!tx_ev.slot_free) begin
			next_s.isr[tx_slot_free_irq] = irq_set[tx_slot_free_irq]; // [R9]
		end

		next_s.awready = !next_s.aw_have;
		next_s.wready = !next_s.w_have;
		next_s.arready = !next_s.rvalid;

		// Pin drive follows the shifter; released for read data phase
		next_s.mdio.mdio_o = next_s.busy ? next_s.sr[31] : 1'b0; // [R17]
		next_s.mdio.mdio_oe = next_s.busy &&
			((next_s.bits < 5'(mgmt_turn_bit)) ||
			!next_s.rd_op); // [R19] [R26]
		next_s.irq = |(next_s.isr & ~next_s.mask[11:0]);
		// Lookup result lags its inputs by one clock
		next_s.hash_hit = hash_enable && hash_all[crc_index]; // [R24]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.mask <= mask_reset; // [R15]
			s.div_sel <= div_sel_reset; // [R23]
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rresp = s.rresp;
	assign s_axi_rdata = s.rdata;
	assign rx_refetch = s.refetch;
	assign rx_buffer_recover = s.recover;
	assign mdio_out = s.mdio;
	assign hash_hit = s.hash_hit;
	assign irq = s.irq;
endmodule : mac_irq_status_phy_mgmt

/* File: tb/mac_status_props.sv */
// Port-level checks for the MAC status and PHY management block
module mac_status_props
	import mac_status_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire mac_status_pkg::rx_dma_ev_t rx_ev,
	input wire logic rx_refetch,
	input wire logic rx_buffer_recover,
	input wire mac_status_pkg::mdio_out_t mdio_out,
	input wire logic hash_enable,
	input wire logic hash_hit
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_wr_answer: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("late write response");
	a_rd_answer: assert property (rd_take |=> s_axi_rvalid)
		else $error("late read data");
	a_rd_single: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_recover_pulse: assert property (
		rx_ev.overrun |=> rx_buffer_recover)
		else $error("buffer not recovered");
	a_refetch_cause: assert property (
		rx_refetch |-> $past(rx_ev.frame_start))
		else $error("refetch without frame start");
	a_hash_gated: assert property (!hash_enable |=> !hash_hit)
		else $error("hit while hashing off");
	a_mdc_hold: assert property (
		$rose(mdio_out.mdc) |-> mdio_out.mdc[*4])
		else $error("mdc high phase too short");
	a_mdio_steady: assert property (
		mdio_out.mdc |-> $stable(mdio_out.mdio_o))
		else $error("mdio moved while mdc high");
endmodule : mac_status_props

bind mac_irq_status_phy_mgmt mac_status_props chk_u (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rx_ev,
	.rx_refetch, .rx_buffer_recover, .mdio_out, .hash_enable, .hash_hit);

/* File: tb/phy_model.sv */
// Behavioural PHY answering management frames on the MDIO wire
module phy_model (
	input wire logic rstn,
	input wire logic mdc,
	input wire logic mdio_oe,
	input wire logic mdio_o,
	input wire logic [15:0] rd_data,
	output logic mdio_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] hdr;
	logic [15:0] sr;
	logic [4:0] cnt;
	logic drv;
	// Pull-up holds the line high when nobody drives it
	assign mdio_i = mdio_oe ? mdio_o : (drv ? sr[15] : 1'b1);
	always @(posedge mdc or negedge rstn) begin
		if (!rstn) begin
			cnt <= 5'h00;
			hdr <= 16'h0000;
		end else begin
			cnt <= cnt + 5'h01;
			if (cnt < 5'h10)
				hdr <= {hdr[14:0], mdio_i};
		end
	end
	always @(negedge mdc or negedge rstn) begin
		if (!rstn) begin
			drv <= 1'b0;
		end else if (cnt == 5'h10 && hdr[13:12] == 2'b10) begin
			drv <= 1'b1;
			sr <= rd_data;
		end else begin
			sr <= {sr[14:0], 1'b0};
			if (cnt == 5'h00)
				drv <= 1'b0;
		end
	end
endmodule : phy_model

/* File: tb/tb_mac_irq_status_phy_mgmt.sv */
// Self-checking bench for the MAC status and PHY management block
module tb_mac_irq_status_phy_mgmt;
	timeunit 1ns;
	timeprecision 1ns;
	import mac_status_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, rx_refetch, irq;
	logic rx_buffer_recover, link_pin, mdio_i, hash_enable, hash_hit;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, hash_filter_low, d, v, m, h;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, bq;
	logic [3:0] s_axi_wstrb;
	logic [5:0] crc_index;
	logic [15:0] phy_data;
	rx_dma_ev_t rx_ev;
	tx_dma_ev_t tx_ev;
	mdio_out_t mdio_out;
	int fail_count, n_checks, per, t0, c, n;
	bit pm;
	int ev_bit[11] = '{2, 1, 10, 4, 5, 7, 8, 11, 3, 9, 6};
	mac_irq_status_phy_mgmt dut_u (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_ev,
		.tx_ev, .rx_refetch, .rx_buffer_recover, .link_pin, .mdio_i,
		.mdio_out, .hash_enable, .crc_index, .hash_filter_low, .hash_hit,
		.irq);
	phy_model phy_u (.rstn(aresetn), .mdc(mdio_out.mdc),
		.mdio_oe(mdio_out.mdio_oe), .mdio_o(mdio_out.mdio_o),
		.rd_data(phy_data), .mdio_i);
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	task automatic hang;
		fail_count++;
		$display("[ERR] %0t timeout", $time);
		finish_test();
	endtask : hang
	task automatic wr(input logic [7:0] a, input logic [31:0] x);
		bit ad = 0, wd = 0, bd = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= x;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 50 && !bd; i++) begin
			@(posedge aclk);
			if (!ad && s_axi_awready) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready) begin
				wd = 1;
				s_axi_wvalid <= 1'b0;
			end
			if (s_axi_bvalid) begin
				bd = 1;
				bq = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
		end
		if (!bd)
			hang();
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] x);
		bit ad = 0, bd = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 50 && !bd; i++) begin
			@(posedge aclk);
			if (!ad && s_axi_arready) begin
				ad = 1;
				s_axi_arvalid <= 1'b0;
			end
			if (s_axi_rvalid) begin
				bd = 1;
				x = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
		end
		if (!bd)
			hang();
	endtask : rd
	function automatic logic hit(input logic [31:0] hi);
		logic [63:0] f = {hi, hash_filter_low};
		return hash_enable & f[crc_index];
	endfunction : hit
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, crc_index} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, link_pin, hash_enable, hash_filter_low} = '0;
		{phy_data, rx_ev, tx_ev} = '0;
		s_axi_wstrb = 4'hf;
		aresetn = 1'b0;
		n = $urandom(1);
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(off_irq_mask, d);
		chk(d, 32'h0000ffff);
		rd(off_net_status_reg, d);
		chk(d[2], 1'b1);
		v = $urandom & 32'hfff;
		wr(off_irq_enable, v);
		m = 32'hffff & ~v;
		rd(off_irq_mask, d);
		chk(d, m);
		v = $urandom & 32'hfff;
		wr(off_irq_disable, v);
		m = m | v;
		rd(off_irq_mask, d);
		chk(d, m);
		$display("test mask done");
		for (int i = 0; i < 11; i++) begin
			@(posedge aclk);
			case (i)
				0: rx_ev <= '{fetch_done: 1'b1, fetch_cpu_owned: 1'b1,
					default: 1'b0};
				1: rx_ev.frame_stored <= 1'b1;
				2: rx_ev.overrun <= 1'b1;
				3: tx_ev.underrun <= 1'b1;
				4: tx_ev.retry_limit <= 1'b1;
				5: tx_ev.frame_done <= 1'b1;
				6: tx_ev.all_sent <= 1'b1;
				7: tx_ev.bus_error <= 1'b1;
				8: tx_ev.reg_write <= 1'b1;
				9: link_pin <= ~link_pin;
				default: tx_ev.slot_free <= 1'b1;
			endcase
			@(posedge aclk);
			rx_ev <= '{frame_start: i == 0, default: 1'b0};
			tx_ev <= '{slot_free: i == 10, default: 1'b0};
			@(posedge aclk);
			chk(rx_buffer_recover, i == 2);
			@(posedge aclk);
			chk(rx_refetch, i == 0);
			rx_ev <= '0;
			chk(irq, !m[ev_bit[i]]);
			rd(off_irq_status, d);
			chk(d, 32'h1 << ev_bit[i]);
		end
		tx_ev <= '0;
		rd(off_rx_status, d);
		chk(d, 32'h7);
		wr(off_rx_status, 32'h3);
		@(posedge aclk);
		rx_ev <= '{fetch_done: 1'b1, fetch_cpu_owned: 1'b1, default: 1'b0};
		@(posedge aclk);
		rx_ev <= '0;
		rd(off_rx_status, d);
		chk(d, 32'h5);
		rd(off_irq_status, d);
		chk(d, 32'h4);
		$display("test events done");
		h = $urandom;
		wr(off_hash_filter_high, h);
		rd(off_hash_filter_high, d);
		chk(d, h);
		repeat (8) begin
			@(posedge aclk);
			hash_enable <= 1'($urandom);
			crc_index <= 6'($urandom);
			hash_filter_low <= $urandom;
			repeat (2) @(posedge aclk);
			chk(hash_hit, hit(h));
		end
		rd(8'h3c, d);
		chk(r, 2'b11);
		wr(8'h3c, $urandom);
		chk(bq, 2'b11);
		$display("test hash done");
		for (int s = 0; s < 4; s++) begin
			// Odd passes read from the PHY, even passes write to it
			v = {2'b01, s[0] ? 2'b10 : 2'b01, 10'($urandom), 2'b10,
				16'($urandom)};
			phy_data = 16'($urandom);
			wr(off_mgmt_config, 32'(s));
			wr(off_phy_maintenance, v);
			rd(off_net_status_reg, d);
			chk(d[2], 1'b0);
			c = 0;
			pm = 1;
			for (n = 0; n < 400 && c < 2; n++) begin
				@(posedge aclk);
				if (mdio_out.mdc && !pm) begin
					c++;
					per = n - t0;
					t0 = n;
				end
				pm = mdio_out.mdc;
			end
			if (c < 2)
				hang();
			chk(per, 8 << s);
			for (n = 0; n < 1000 && d[2] !== 1'b1; n++)
				rd(off_net_status_reg, d);
			if (d[2] !== 1'b1)
				hang();
			rd(off_phy_maintenance, d);
			chk(d, s[0] ? {v[31:16], phy_data} : v);
			rd(off_irq_status, d);
			chk(d, 32'h1);
			rd(off_irq_status, d);
			chk(d, 32'h0);
		end
		$display("test mdio done");
		finish_test();
	end
endmodule : tb_mac_irq_status_phy_mgmt
